/* rtl/ashr_pkg.sv */
// Purpose: Constants and types for the converter readout host controller.
// Assumes: 100 MHz system clock, classic Wishbone slave with 32-bit data.
// Notes: Byte addresses below are word aligned.
package ashr_pkg;
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned SCK_HZ = 4190000;
    // Half period of the serial clock, rounded down so the clock is never slower
    localparam int unsigned SCK_HALF_CYC = CLK_HZ / (2 * SCK_HZ);
    localparam int unsigned POST_DELAY_NS = 19000;
    localparam int unsigned POST_DELAY_CYC = (POST_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CONVERT_BITS = 8;
    localparam int unsigned RESULT_BITS = 16;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_HALF = 8'h08;
    localparam logic [7:0] ADR_DELAY = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_DATA = 8'h14;
    localparam logic [7:0] ADR_COUNT = 8'h18;

    localparam int unsigned CTRL_ENABLE = 0;
    localparam int unsigned CTRL_HOST_CONV = 1;
    localparam int unsigned CTRL_AUTO = 2;
    localparam int unsigned CMD_START = 0;
    localparam int unsigned ST_VALID = 0;
    localparam int unsigned ST_OVERRUN = 1;
    localparam int unsigned ST_RUNNING = 2;
    localparam int unsigned ST_CONV_PHASE = 3;

    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [15:0] HALF_RESET = 16'(SCK_HALF_CYC);
    localparam logic [15:0] DELAY_RESET = 16'(POST_DELAY_CYC);

    typedef enum logic [1:0] {
        ASHR_IDLE = 2'b00,
        ASHR_XFER = 2'b01,
        ASHR_DELAY = 2'b11,
        ASHR_ARM = 2'b10
    } ashr_state_t;

    // Pins driven toward the converter
    typedef struct packed {
        logic host_select_zero;
        logic host_select_one;
        logic sclk;
    } ashr_pins_t;
endpackage

/* rtl/ashr_host.sv */
// Purpose: Host controller reading a 16-bit sampling converter over its serial pins.
// Assumes: Converter pins are asynchronous to clk_i; software drives classic Wishbone.
// Notes: Two modes: busy-triggered readout, or host-issued convert/read transfer pairs.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module ashr_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic busy_i,
    input wire logic parallel_msb_out_i,
    input wire logic serial_result_out_i,
    output ashr_pkg::ashr_pins_t pins_o
);
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [2:0] ctrl;
    logic [15:0] half_cyc;
    logic [15:0] delay_cyc;
    logic [15:0] result;
    logic [31:0] conv_count;
    logic valid;
    logic overrun;
    logic start_req;
    ashr_pkg::ashr_state_t state;
    logic conv_phase;
    logic [15:0] div_cnt;
    logic [15:0] delay_cnt;
    logic [4:0] bit_cnt;
    logic [15:0] shreg;
    logic busy_s1, busy_s2, busy_s3;
    logic msb_s1, msb_s2;
    logic sd_s1, sd_s2;

    logic access;
    logic wr;
    logic rd;
    logic half_tick;
    logic sclk_rise;
    logic last_fall;
    logic busy_rise;
    logic data_in;
    logic [4:0] xfer_len;
    logic result_done;

    assign access = wb_cyc_i && wb_stb_i && wb_ack_o;
    assign wr = access && wb_we_i;
    assign rd = access && !wb_we_i;
    assign half_tick = (state == ashr_pkg::ASHR_XFER) && (div_cnt == 16'h0000);
    assign sclk_rise = half_tick && !pins_o.sclk;
    assign xfer_len = conv_phase ? 5'(ashr_pkg::CONVERT_BITS) : 5'(ashr_pkg::RESULT_BITS);
    assign last_fall = half_tick && pins_o.sclk && (bit_cnt == xfer_len);
    assign busy_rise = busy_s2 && !busy_s3;
    // Tri-stateable MSB pin shares the line with other peripherals
    assign data_in = ctrl[ashr_pkg::CTRL_HOST_CONV] ? msb_s2 : sd_s2;
    assign result_done = last_fall && !conv_phase;

    // Two-stage synchronisers for converter pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_s1 <= 1'b1;
            busy_s2 <= 1'b1;
            busy_s3 <= 1'b1;
            msb_s1 <= 1'b0;
            msb_s2 <= 1'b0;
            sd_s1 <= 1'b0;
            sd_s2 <= 1'b0;
        end else begin
            busy_s1 <= busy_i;
            busy_s2 <= busy_s1;
            busy_s3 <= busy_s2;
            msb_s1 <= parallel_msb_out_i;
            msb_s2 <= msb_s1;
            sd_s1 <= serial_result_out_i;
            sd_s2 <= sd_s1;
        end
    end

    // Wishbone answer one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            unique case (wb_adr_i)
                ashr_pkg::ADR_CTRL: wb_dat_o <= {29'h0000_0000, ctrl};
                ashr_pkg::ADR_HALF: wb_dat_o <= {16'h0000, half_cyc};
                ashr_pkg::ADR_DELAY: wb_dat_o <= {16'h0000, delay_cyc};
                ashr_pkg::ADR_STATUS: wb_dat_o <= {28'h000_0000, conv_phase,
                    (state != ashr_pkg::ASHR_IDLE), overrun, valid};
                ashr_pkg::ADR_DATA: wb_dat_o <= {16'h0000, result};
                ashr_pkg::ADR_COUNT: wb_dat_o <= conv_count;
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= ashr_pkg::CTRL_RESET;
            half_cyc <= ashr_pkg::HALF_RESET;
            delay_cyc <= ashr_pkg::DELAY_RESET;
        end else if (wr) begin
            unique case (wb_adr_i)
                ashr_pkg::ADR_CTRL: ctrl <= 3'(merge_bytes({29'h0, ctrl}, wb_dat_i, wb_sel_i));
                // Zero half period would stall the shifter; floor it at one
                ashr_pkg::ADR_HALF: half_cyc <= (merge_bytes({16'h0, half_cyc}, wb_dat_i,
                    wb_sel_i) == 32'h0) ? 16'h0001 :
                    16'(merge_bytes({16'h0, half_cyc}, wb_dat_i, wb_sel_i));
                ashr_pkg::ADR_DELAY: delay_cyc <= 16'(merge_bytes({16'h0, delay_cyc}, wb_dat_i,
                    wb_sel_i));
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_req <= 1'b0;
        end else if (wr && wb_adr_i == ashr_pkg::ADR_CMD && wb_sel_i[0]
                     && wb_dat_i[ashr_pkg::CMD_START]) begin
            start_req <= 1'b1;
        end else if (state == ashr_pkg::ASHR_IDLE) begin
            start_req <= 1'b0;
        end
    end

    // Sequencer: host mode runs convert transfer, delay, data transfer, delay; busy mode arms, then one data transfer
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl[ashr_pkg::CTRL_ENABLE]) begin
            state <= ashr_pkg::ASHR_IDLE;
            conv_phase <= 1'b0;
            delay_cnt <= 16'h0000;
        end else begin
            unique case (state)
                ashr_pkg::ASHR_IDLE: begin
                    if (!ctrl[ashr_pkg::CTRL_HOST_CONV]) begin
                        state <= ashr_pkg::ASHR_ARM;
                        conv_phase <= 1'b0;
                    end else if (ctrl[ashr_pkg::CTRL_AUTO] || start_req) begin
                        state <= ashr_pkg::ASHR_XFER;
                        conv_phase <= 1'b1;
                    end
                end
                ashr_pkg::ASHR_ARM: begin
                    // A mode change while armed must not wait on a busy edge that never comes
                    if (ctrl[ashr_pkg::CTRL_HOST_CONV]) begin
                        state <= ashr_pkg::ASHR_IDLE;
                    end else if (busy_rise) begin
                        state <= ashr_pkg::ASHR_XFER;
                    end
                end
                ashr_pkg::ASHR_XFER: begin
                    if (last_fall) begin
                        if (ctrl[ashr_pkg::CTRL_HOST_CONV]) begin
                            state <= ashr_pkg::ASHR_DELAY;
                            delay_cnt <= delay_cyc;
                        end else begin
                            state <= ashr_pkg::ASHR_ARM;
                        end
                    end
                end
                ashr_pkg::ASHR_DELAY: begin
                    if (delay_cnt > 16'h0001) begin
                        delay_cnt <= delay_cnt - 16'h0001;
                    end else if (conv_phase) begin
                        state <= ashr_pkg::ASHR_XFER;
                        conv_phase <= 1'b0;
                    end else if (ctrl[ashr_pkg::CTRL_AUTO]) begin
                        state <= ashr_pkg::ASHR_XFER;
                        conv_phase <= 1'b1;
                    end else begin
                        state <= ashr_pkg::ASHR_IDLE;
                    end
                end
            endcase
        end
    end

    // Serial clock and bit shifter, clock idles low
    always_ff @(posedge clk_i) begin
        if (rst_i || state != ashr_pkg::ASHR_XFER) begin
            pins_o.sclk <= 1'b0;
            // First rise one cycle short of a full half period after select, so the synced pin is settled
            div_cnt <= half_cyc - 16'h0001;
            bit_cnt <= 5'h00;
            shreg <= 16'h0000;
        end else if (half_tick) begin
            div_cnt <= half_cyc - 16'h0001;
            pins_o.sclk <= !pins_o.sclk && !last_fall;
            if (sclk_rise) begin
                bit_cnt <= bit_cnt + 5'h01;
                shreg <= {shreg[14:0], data_in};
            end
            if (last_fall) begin
                bit_cnt <= 5'h00;
            end
        end else begin
            div_cnt <= div_cnt - 16'h0001;
        end
    end

    // Select pins: convert transfer pulls both low, data transfer only chip select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_o.host_select_zero <= 1'b1;
            pins_o.host_select_one <= 1'b1;
        end else if (state == ashr_pkg::ASHR_XFER && !last_fall) begin
            pins_o.host_select_zero <= !conv_phase;
            pins_o.host_select_one <= 1'b0;
        end else begin
            pins_o.host_select_zero <= 1'b1;
            pins_o.host_select_one <= 1'b1;
        end
    end

    // Whole word captured at once so upper byte is never lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result <= 16'h0000;
            conv_count <= 32'h0000_0000;
        end else if (result_done) begin
            result <= shreg;
            conv_count <= conv_count + 32'h0000_0001;
        end
    end

    // New result wins over a read that clears it in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid <= 1'b0;
        end else if (result_done) begin
            valid <= 1'b1;
        end else if (rd && wb_adr_i == ashr_pkg::ADR_DATA) begin
            valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overrun <= 1'b0;
        end else if (result_done && valid) begin
            overrun <= 1'b1;
        end else if (wr && wb_adr_i == ashr_pkg::ADR_STATUS && wb_sel_i[0]
                     && wb_dat_i[ashr_pkg::ST_OVERRUN]) begin
            overrun <= 1'b0;
        end
    end
endmodule // ashr_host
`default_nettype wire

/* tb/ashr_host_props.sv */
// Purpose: Port checks for the converter readout host.
// Assumes: HALF set to at least 3, DELAY to at least 8.
// Notes: Bit counts come from small helper counters.
`timescale 1ns/100ps
`default_nettype none
module ashr_host_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire ashr_pkg::ashr_pins_t pins_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic s0 = pins_o.host_select_zero;
    wire logic s1 = pins_o.host_select_one;
    logic sclk_q;
    logic [4:0] conv_bits, data_bits;
    always_ff @(posedge clk_i) sclk_q <= pins_o.sclk;
    always_ff @(posedge clk_i) begin
        if (rst_i || s0) conv_bits <= 5'h00;
        else if (pins_o.sclk && !sclk_q) conv_bits <= conv_bits + 5'h01;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || s1 || !s0) data_bits <= 5'h00;
        else if (pins_o.sclk && !sclk_q) data_bits <= data_bits + 5'h01;
    end
    sequence conv_end; $rose(s0); endsequence
    sequence data_start; $fell(s1) && s0; endsequence
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_sclk_idle: assert property (s0 && s1 |-> !pins_o.sclk)
        else $error("serial clock high while deselected");
    a_convert_both: assert property (!s0 |-> !s1)
        else $error("convert select without chip select");
    a_convert_eight: assert property (conv_end |-> conv_bits == 5'h08)
        else $error("convert transfer not eight clocks");
    a_data_sixteen: assert property ($rose(s1) && $past(s0) |-> data_bits == 5'h10)
        else $error("data transfer not sixteen clocks");
    a_post_gap: assert property ($rose(s1) |-> s1 [*8])
        else $error("no delay after transfer");
    a_data_follows: assert property (conv_end |-> ##[8:1000] data_start)
        else $error("no data transfer after convert");
    a_sclk_gated: assert property ($rose(pins_o.sclk) |-> !s1 ##1 pins_o.sclk [*2])
        else $error("serial clock outside select or too short");
endmodule // ashr_host_props
`default_nettype wire

/* tb/ashr_adc_model.sv */
// Purpose: Behavioural converter on the far side of the host.
// Assumes: Bits change on serial clock fall, read on the rise.
// Notes: Loads the sample input when a conversion ends.
`timescale 1ns/100ps
`default_nettype none
module ashr_adc_model #(parameter int CONV_CYC = 100) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [15:0] sample_i,
    input wire ashr_pkg::ashr_pins_t pins_i,
    output logic busy_o,
    output logic msb_o,
    output logic sdo_o
);
    logic [15:0] word;
    logic [7:0] left;
    logic both_q, sclk_q, both, rd_sel;
    assign both = !pins_i.host_select_zero && !pins_i.host_select_one;
    assign rd_sel = pins_i.host_select_zero && !pins_i.host_select_one;
    // Deselected lines show the inverse, so a stale sample cannot match
    assign msb_o = rd_sel ? word[15] : !word[15];
    assign sdo_o = rd_sel ? word[15] : !word[15];
    always_ff @(posedge clk_i) begin
        both_q <= both;
        sclk_q <= pins_i.sclk;
        if (rst_i) begin
            busy_o <= 1'b1;
            left <= 8'h00;
            word <= 16'h0000;
        end else if (busy_o && (start_i || (both && !both_q))) begin
            busy_o <= 1'b0;
            left <= 8'(CONV_CYC);
        end else if (!busy_o) begin
            left <= left - 8'h01;
            if (left == 8'h01) begin
                busy_o <= 1'b1;
                word <= sample_i;
            end
        end else if (rd_sel && sclk_q && !pins_i.sclk) begin
            word <= {word[14:0], !word[15]};
        end
    end
endmodule // ashr_adc_model
`default_nettype wire

/* tb/ashr_host_bench.sv */
// Purpose: Self-checking bench for the converter readout host.
// Assumes: Converter model answers on the serial pins.
// Notes: Reads note expectations; a monitor compares at ack.
`timescale 1ns/100ps
`default_nettype none
module ashr_host_bench;
    logic clk, rst, cyc, stb, we, ack, busy, msb, sdo, start;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, v;
    logic [15:0] sample, smp;
    logic [40:0] nt;
    logic [40:0] notes[$];
    ashr_pkg::ashr_pins_t pins;
    int errors = 0;
    int total_checks = 0;
    int seed = 83;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ashr_host ashr_host_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .busy_i(busy), .parallel_msb_out_i(msb),
        .serial_result_out_i(sdo), .pins_o(pins));
    ashr_adc_model ashr_adc_model_inst (.clk_i(clk), .rst_i(rst), .start_i(start),
        .sample_i(sample), .pins_i(pins), .busy_o(busy), .msb_o(msb), .sdo_o(sdo));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        if (!w) notes.push_back({c, a, d});
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) errors++;
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_valid;
        int k;
        k = 0;
        do begin
            bus(1'b0, ashr_pkg::ADR_STATUS, 32'h0, 1'b0);
            k++;
        end while (v[ashr_pkg::ST_VALID] !== 1'b1 && k < 400);
        check("status_valid", {31'h0, v[ashr_pkg::ST_VALID]}, 32'h1);
    endtask
    // Monitor: each read ack takes the oldest note
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt[40]) check($sformatf("read_%h", nt[39:32]), rdat, nt[31:0]);
        end
    end
    initial begin
        {cyc, stb, we, start, rst} = 5'h01;
        {adr, sel, wdat, sample} = {8'h00, 4'hF, 32'h0, 16'h0000};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b1, 8'h1C, 32'hFFFFFFFF, 1'b0);
        bus(1'b0, 8'h1C, 32'h0, 1'b1);
        bus(1'b0, ashr_pkg::ADR_HALF, {16'h0, ashr_pkg::HALF_RESET}, 1'b1);
        bus(1'b0, ashr_pkg::ADR_DELAY, {16'h0, ashr_pkg::DELAY_RESET}, 1'b1);
        bus(1'b1, ashr_pkg::ADR_HALF, 32'h5, 1'b0);
        bus(1'b1, ashr_pkg::ADR_DELAY, 32'h96, 1'b0);
        $display("Test reset values done");
        smp = 16'($random(seed));
        sample <= smp;
        bus(1'b1, ashr_pkg::ADR_CTRL, 32'h3, 1'b0);
        bus(1'b1, ashr_pkg::ADR_CMD, 32'h1, 1'b0);
        wait_valid;
        bus(1'b0, ashr_pkg::ADR_DATA, {16'h0, smp}, 1'b1);
        bus(1'b0, ashr_pkg::ADR_COUNT, 32'h1, 1'b1);
        $display("Test host convert done");
        bus(1'b1, ashr_pkg::ADR_CTRL, 32'h1, 1'b0);
        smp = 16'($random(seed));
        sample <= smp;
        repeat (40) @(posedge clk);
        bus(1'b0, ashr_pkg::ADR_COUNT, 32'h1, 1'b1);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wait_valid;
        bus(1'b0, ashr_pkg::ADR_DATA, {16'h0, smp}, 1'b1);
        $display("Test busy readout done");
        for (int i = 0; i < 2; i++) begin
            smp = 16'($random(seed));
            sample <= smp;
            if (i == 0) bus(1'b1, ashr_pkg::ADR_CTRL, 32'h7, 1'b0);
            wait_valid;
            bus(1'b0, ashr_pkg::ADR_DATA, {16'h0, smp}, 1'b1);
        end
        bus(1'b1, ashr_pkg::ADR_CTRL, 32'h0, 1'b0);
        repeat (20) @(posedge clk);
        check("selects", {30'h0, pins.host_select_zero, pins.host_select_one}, 32'h3);
        $display("Test auto wrap done");
        tally_and_finish;
    end
    initial begin
        #500000;
        errors++;
        tally_and_finish;
    end
endmodule // ashr_host_bench
bind ashr_host ashr_host_props ashr_host_props_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pins_o(pins_o));
`default_nettype wire
